// ==== cdc_params.svh ====
`ifndef CDC_PARAMS_SVH
`define CDC_PARAMS_SVH

`define CDC_NUM_PORTS 3
`define CDC_CODE_NONE 3'h0
`define CDC_CODE_DCP 3'h1
`define CDC_CODE_CDP 3'h2
`define CDC_CODE_SDP 3'h3
`define CDC_CODE_PROP_LOW 3'h4
`define CDC_CODE_PROP_HIGH 3'h5
`define CDC_CODE_PROP_SUPER 3'h6
`define CDC_PROBE_NS 1000
`define CDC_CLK_NS 4
`define CDC_PROBE_CYCLES ((`CDC_PROBE_NS + `CDC_CLK_NS - 1) / `CDC_CLK_NS)
`define CDC_CLASS_SDP 2'h0
`define CDC_CLASS_CDP 2'h1
`define CDC_CLASS_DCP 2'h2

`endif

// ==== cdc_pkg.sv ====
package cdc_pkg;

    typedef enum logic [2:0] {
        CDC_ST_IDLE,
        CDC_ST_DRIVE,
        CDC_ST_SENSE,
        CDC_ST_REPORT,
        CDC_ST_DONE
    } cdc_state_e;

    // Levels sensed on the upstream data lines by the analog comparators.
    typedef struct packed {
        logic lines_shorted;
        logic dm_reflects_dp;
        logic pulldowns_seen;
        logic prop_low;
        logic prop_high;
        logic prop_super;
    } cdc_sense_s;

    // Drive requests to the upstream data line sources.
    typedef struct packed {
        logic dp_source_on;
        logic dm_sink_on;
    } cdc_drive_s;

    typedef logic [1:0] cdc_class_t;

endpackage

// ==== cdc_classify.sv ====
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_classify (
    input wire logic [5:0] sense,
    input wire logic enhanced_detect_enable,
    output logic [2:0] code
);
    import cdc_pkg::*;

    cdc_sense_s s;

    assign s = cdc_sense_s'(sense);

    // Priority runs from the most specific profile to the least.
    always_comb begin
        code = `CDC_CODE_NONE;
        if (s.lines_shorted) begin
            code = `CDC_CODE_DCP;
        end else if (s.dm_reflects_dp && enhanced_detect_enable) begin
            code = `CDC_CODE_CDP;
        end else if (s.prop_super) begin
            code = `CDC_CODE_PROP_SUPER;
        end else if (s.prop_high) begin
            code = `CDC_CODE_PROP_HIGH;
        end else if (s.prop_low) begin
            code = `CDC_CODE_PROP_LOW;
        end else if (s.pulldowns_seen) begin
            code = `CDC_CODE_SDP;
        end
    end
endmodule

// ==== cdc_port_class.sv ====
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_port_class (
    input wire logic charge_cfg,
    input wire logic host_present,
    output logic [1:0] port_class
);
    import cdc_pkg::*;

    always_comb begin
        if (!charge_cfg) begin
            port_class = `CDC_CLASS_SDP;
        end else if (host_present) begin
            port_class = `CDC_CLASS_CDP;
        end else begin
            port_class = `CDC_CLASS_DCP;
        end
    end
endmodule

// ==== cdc_charger_detect.sv ====
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_charger_detect #(
    parameter int NUM_PORTS = `CDC_NUM_PORTS,
    parameter int PROBE_CYCLES = `CDC_PROBE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic detect_enable,
    input wire logic enhanced_detect_enable,
    input wire logic charger_detect_stage,
    input wire logic wait_reference_clock_stage,
    input wire logic osc_detect_enable,
    input wire logic reference_clock_active,
    input wire logic [NUM_PORTS:1] charge_enable_strap,
    input wire logic config_done,
    input wire logic [NUM_PORTS:1] host_present,
    input wire logic [NUM_PORTS:1] charge_query,
    input wire cdc_pkg::cdc_sense_s upstream_sense,
    input wire logic custom_ctrl_valid,
    input wire cdc_pkg::cdc_drive_s custom_drive,
    input wire logic status_read,
    output cdc_pkg::cdc_drive_s upstream_drive,
    output logic [2:0] charger_type,
    output logic charger_irq,
    output logic [NUM_PORTS:1] charge_enable,
    output logic [NUM_PORTS:1] port_power_out,
    output logic [NUM_PORTS:1] charge_query_ack,
    output logic [2*NUM_PORTS-1:0] port_class
);
    import cdc_pkg::*;

    localparam int CW = $clog2(PROBE_CYCLES + 1);

    typedef struct packed {
        cdc_state_e state;
        logic [CW-1:0] timer;
        cdc_drive_s drive;
        logic [2:0] code;
        logic irq;
        logic locked;
        logic [NUM_PORTS:1] enable;
        logic [NUM_PORTS:1] power;
        logic [NUM_PORTS:1] ack;
        logic [2*NUM_PORTS-1:0] cls;
        logic stage_seen;
    } cdc_regs_s;

    cdc_regs_s r;
    cdc_regs_s next_r;
    logic [2:0] sensed_code;
    logic [2*NUM_PORTS-1:0] live_class;
    logic start_ok;

    cdc_classify u_classify (
        .sense(upstream_sense),
        .enhanced_detect_enable(enhanced_detect_enable),
        .code(sensed_code)
    );

    genvar gi;
    generate
        for (gi = 1; gi <= NUM_PORTS; gi++) begin : g_port
            cdc_port_class u_class (
                .charge_cfg(r.enable[gi]),
                .host_present(host_present[gi]),
                .port_class(live_class[2*gi-1 -: 2])
            );
        end
    endgenerate

    // Detection may run on the oscillator while the reference clock is absent.
    assign start_ok = charger_detect_stage ||
        (wait_reference_clock_stage && osc_detect_enable);

    always_comb begin
        next_r = r;
        next_r.stage_seen = start_ok;
        if (status_read) begin
            next_r.irq = 1'b0;
        end
        case (r.state)
            CDC_ST_IDLE: begin
                next_r.drive = '0;
                // Start on entry to the stage, only for the upstream port.
                if (detect_enable && start_ok && !r.stage_seen) begin
                    next_r.state = CDC_ST_DRIVE;
                    next_r.timer = CW'(PROBE_CYCLES);
                end
            end
            CDC_ST_DRIVE: begin
                next_r.drive.dp_source_on = 1'b1;
                next_r.drive.dm_sink_on = 1'b1;
                next_r.state = CDC_ST_SENSE;
            end
            CDC_ST_SENSE: begin
                if (r.timer <= CW'(1)) begin
                    next_r.state = CDC_ST_REPORT;
                end else begin
                    next_r.timer = r.timer - CW'(1);
                end
            end
            CDC_ST_REPORT: begin
                next_r.drive = '0;
                next_r.code = sensed_code;
                if (sensed_code != `CDC_CODE_NONE) begin
                    next_r.irq = 1'b1;
                end
                next_r.state = CDC_ST_DONE;
            end
            CDC_ST_DONE: begin
                if (!start_ok) begin
                    next_r.state = CDC_ST_IDLE;
                end
            end
            default: begin
                next_r.state = CDC_ST_IDLE;
            end
        endcase
        // Custom control is honoured at every stage; software owns timing.
        if (custom_ctrl_valid) begin
            next_r.drive = custom_drive;
        end
        if (!r.locked && config_done) begin
            next_r.locked = 1'b1;
            next_r.enable = charge_enable_strap;
        end
        next_r.power = r.enable;
        next_r.ack = charge_query & r.enable;
        // Class holds SDP until locked, then only moves between CDP and DCP; SDP ports stay SDP.
        next_r.cls = r.locked ? live_class : '0;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.state <= CDC_ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign upstream_drive = r.drive;
    assign charger_type = r.code;
    assign charger_irq = r.irq;
    assign charge_enable = r.enable;
    assign port_power_out = r.power;
    assign charge_query_ack = r.ack;
    assign port_class = r.cls;
endmodule

// ==== cdc_charger_model.sv ====
`timescale 1ns/100ps
module cdc_charger_model (
    input wire cdc_pkg::cdc_drive_s upstream_drive,
    input wire logic [5:0] profile,
    output cdc_pkg::cdc_sense_s upstream_sense
);
    // The comparators only see the charger while the probe source is on.
    assign upstream_sense = upstream_drive.dp_source_on ? profile : 6'h0;
endmodule

// ==== cdc_charger_detect_properties.sv ====
`timescale 1ns/100ps
`include "cdc_params.svh"
module cdc_charger_detect_checker #(
    parameter int NUM_PORTS = 3,
    parameter int PROBE_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic detect_enable,
    input wire logic enhanced_detect_enable,
    input wire logic charger_detect_stage,
    input wire logic custom_ctrl_valid,
    input wire cdc_pkg::cdc_drive_s custom_drive,
    input wire logic status_read,
    input wire logic [NUM_PORTS:1] charge_query,
    input wire cdc_pkg::cdc_drive_s upstream_drive,
    input wire logic [2:0] charger_type,
    input wire logic charger_irq,
    input wire logic [NUM_PORTS:1] charge_enable,
    input wire logic [NUM_PORTS:1] port_power_out,
    input wire logic [NUM_PORTS:1] charge_query_ack
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_start;
        !custom_ctrl_valid && $rose(detect_enable && charger_detect_stage);
    endsequence
    sequence s_probe;
        ##2 upstream_drive == 2'h3;
    endsequence
    property p_start; s_start |-> s_probe; endproperty
    a_start: assert property (p_start) else $error("no probe");
    property p_cdp;
        $changed(charger_type) && charger_type == `CDC_CODE_CDP |-> enhanced_detect_enable;
    endproperty
    a_cdp: assert property (p_cdp) else $error("cdp code");
    property p_irq; $rose(charger_irq) |-> charger_type != 3'h0; endproperty
    a_irq: assert property (p_irq) else $error("irq code");
    property p_clear; $fell(charger_irq) |-> $past(status_read); endproperty
    a_clear: assert property (p_clear) else $error("irq drop");
    property p_custom; custom_ctrl_valid |=> upstream_drive == $past(custom_drive); endproperty
    a_custom: assert property (p_custom) else $error("custom");
    property p_power; port_power_out == $past(charge_enable); endproperty
    a_power: assert property (p_power) else $error("power");
    property p_ack; charge_query_ack == $past(charge_query & charge_enable); endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_lock; charge_enable != 3'h0 |=> $stable(charge_enable); endproperty
    a_lock: assert property (p_lock) else $error("lock");
endmodule
bind cdc_charger_detect cdc_charger_detect_checker #(
    .NUM_PORTS(NUM_PORTS), .PROBE_CYCLES(PROBE_CYCLES)) u_chk (.*);

// ==== test_charger_detect_control.sv ====
`timescale 1ns/100ps
module test_charger_detect_control;
    logic sys_clk = 0, sys_rst = 1, detect_enable = 0, enhanced_detect_enable = 0;
    logic charger_detect_stage = 0, wait_reference_clock_stage = 0, osc_detect_enable = 0;
    logic reference_clock_active = 0, config_done = 0, custom_ctrl_valid = 0, status_read = 0;
    logic [3:1] charge_enable_strap = 0, host_present = 0, charge_query = 0;
    logic [3:1] charge_enable, port_power_out, charge_query_ack;
    cdc_pkg::cdc_sense_s upstream_sense;
    cdc_pkg::cdc_drive_s custom_drive = 0, upstream_drive;
    logic [2:0] charger_type;
    logic charger_irq;
    logic [5:0] port_class, profile = 0;
    int fails = 0, n_tests = 0;
    always #2 sys_clk = ~sys_clk;
    cdc_charger_detect #(.NUM_PORTS(3), .PROBE_CYCLES(4)) DUT (.*);
    cdc_charger_model partner (.*);
    task check(input string what, input logic [5:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task test_config;
        tick(1);
        charge_enable_strap <= 3'h5;
        host_present <= 3'h1;
        config_done <= 1'h1;
        tick(1);
        config_done <= 1'h0;
        charge_enable_strap <= 3'h2;
        tick(4);
        check("enable", charge_enable, 3'h5);
        check("power", port_power_out, 3'h5);
        check("class", port_class, 6'h21);
        config_done <= 1'h1;
        host_present <= 3'h0;
        tick(1);
        config_done <= 1'h0;
        tick(4);
        check("relock", charge_enable, 3'h5);
        check("dcp", port_class, 6'h22);
        charge_query <= 3'h7;
        tick(2);
        check("ack", charge_query_ack, 3'h5);
        charge_query <= 3'h0;
    endtask
    task detect(input logic [5:0] prof, input logic enh, osc, input logic [2:0] exp);
        int k;
        tick(1);
        profile <= prof;
        enhanced_detect_enable <= enh;
        detect_enable <= 1'h1;
        osc_detect_enable <= osc;
        wait_reference_clock_stage <= osc;
        charger_detect_stage <= !osc;
        for (k = 0; k < 20 && charger_irq !== 1'h1; k++) tick(1);
        check("type", charger_type, exp);
        check("irq", charger_irq, exp != 3'h0);
        status_read <= 1'h1;
        charger_detect_stage <= 1'h0;
        wait_reference_clock_stage <= 1'h0;
        tick(1);
        status_read <= 1'h0;
        tick(2);
        check("clear", charger_irq, 1'h0);
    endtask
    task test_custom;
        tick(1);
        // Custom control is only driven here, with both detection stages low.
        custom_ctrl_valid <= 1'h1;
        custom_drive <= 2'h1;
        tick(2);
        check("custom", upstream_drive, 2'h1);
        custom_ctrl_valid <= 1'h0;
    endtask
    initial begin
        tick(20);
        sys_rst <= 1'h0;
        test_config;
        detect(6'h20, 1'h1, 1'h0, 3'h1);
        detect(6'h10, 1'h0, 1'h0, 3'h0);
        detect(6'h10, 1'h1, 1'h0, 3'h2);
        detect(6'h08, 1'h1, 1'h0, 3'h3);
        detect(6'h04, 1'h1, 1'h0, 3'h4);
        detect(6'h02, 1'h1, 1'h0, 3'h5);
        detect(6'h01, 1'h1, 1'h0, 3'h6);
        detect(6'h20, 1'h1, 1'h1, 3'h1);
        detect(6'h00, 1'h1, 1'h0, 3'h0);
        test_custom;
        complete_run;
    end
    initial begin
        #20000;
        fails++;
        complete_run;
    end
endmodule
